// *** design/haptic_cfg_pkg.sv ***
package haptic_cfg_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_STOP_PHASE_TIME_ADJUST  = 8'h10;
  localparam logic [7:0] ADDR_AUDIO_VIBE_PATH_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_AUDIO_INPUT_FLOOR       = 8'h12;
  localparam logic [7:0] ADDR_AUDIO_INPUT_FULL_SCALE  = 8'h13;
  localparam logic [7:0] ADDR_VIBE_DRIVE_FLOOR        = 8'h14;
  localparam logic [7:0] ADDR_VIBE_DRIVE_CEILING      = 8'h15;
  localparam logic [7:0] ADDR_MOTOR_NOMINAL_LEVEL     = 8'h16;
  localparam logic [7:0] ADDR_OVERDRIVE_LIMIT_LEVEL   = 8'h17;

  // values after reset
  localparam logic [7:0] RST_STOP_PHASE_TIME_ADJUST = 8'h00;
  localparam logic [1:0] RST_AUDIO_PEAK_WINDOW_SEL  = 2'h1;
  localparam logic [1:0] RST_AUDIO_LOWPASS_SEL      = 2'h1;
  localparam logic [7:0] RST_AUDIO_INPUT_FLOOR      = 8'h19;
  localparam logic [7:0] RST_AUDIO_INPUT_FULL_SCALE = 8'hff;
  localparam logic [7:0] RST_VIBE_DRIVE_FLOOR       = 8'h19;
  localparam logic [7:0] RST_VIBE_DRIVE_CEILING     = 8'hff;
  localparam logic [7:0] RST_MOTOR_NOMINAL_LEVEL    = 8'h3f;
  localparam logic [7:0] RST_OVERDRIVE_LIMIT_LEVEL  = 8'h89;

  // field positions of the path control register
  localparam int PEAK_SEL_LSB    = 2;
  localparam int LOWPASS_SEL_LSB = 0;

  // timing
  localparam int CLOCK_PERIOD_NS     = 20;
  localparam int MS_TICK_TIME_NS     = 1000000;
  localparam int MS_TICK_CYCLES      = MS_TICK_TIME_NS / CLOCK_PERIOD_NS;
  localparam int STOP_PHASE_STEP_MS  = 5;
  localparam int PEAK_WINDOW_STEP_MS = 10;

  // one-pole low-pass gains (of 256) at a 1 ms update for 100/125/150/200 Hz
  localparam logic [7:0] LOWPASS_GAIN_0 = 8'h78;
  localparam logic [7:0] LOWPASS_GAIN_1 = 8'h8b;
  localparam logic [7:0] LOWPASS_GAIN_2 = 8'h9c;
  localparam logic [7:0] LOWPASS_GAIN_3 = 8'hb7;

  typedef enum logic [1:0] {
    COLLECT = 2'b01,
    PLAY    = 2'b10
  } wave_state_type;

endpackage : haptic_cfg_pkg

// *** design/haptic_brake_audio_vibe_cfg.sv ***
// How it works
// - The signed stop-phase adjust byte lengthens or shortens the braking segment by its value times 5 ms.
// - The braking segment is the one holding the most negative drive level of the waveform.
// - The stop-phase adjust acts only in open loop; in closed loop braking lengths pass unchanged.
// - Bits 3-2 of the path control register pick a 10/20/30/40 ms peak window, reset code 1.
// - Bits 1-0 of the path control register pick a 100/125/150/200 Hz low-pass, reset code 1.
// - Filtered input below the input floor (reset 0x19) is ignored and gives zero drive.
// - The input full-scale code (reset 0xff) is the input level that maps to full drive.
// - While the ceiling is at or above the drive floor (reset 0x19), a nonzero audio drive never falls below the floor.
// - Audio drive never exceeds the drive ceiling (reset 0xff).
// - The motor nominal level (reset 0x3f) is the full-scale reference in closed loop.
// - The motor nominal level is left out of the full-scale reference in open loop but still drives cal_rated_level.
// - The overdrive limit level is the open-loop full-scale reference and the closed-loop bound.
module haptic_brake_audio_vibe_cfg
  import haptic_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = MS_TICK_CYCLES,
  parameter int MAX_SEGS    = 8
)(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // register port from the serial bus decoder
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  // operating mode
  input  wire logic                 closed_loop,
  // library waveform segments in
  input  wire logic                 wave_in_valid,
  input  wire logic signed [7:0]    wave_in_level,
  input  wire logic [11:0]          wave_in_dur_ms,
  input  wire logic                 wave_in_last,
  output logic                      wave_in_ready,
  // adjusted waveform segments out
  output logic                      wave_out_valid,
  output logic signed [7:0]         wave_out_level,
  output logic [11:0]               wave_out_dur_ms,
  output logic                      wave_out_last,
  output logic                      wave_out_brake,
  // audio path, sampled amplitude code on this clock
  input  wire logic [7:0]           audio_level,
  output logic [7:0]                audio_drive,
  output logic                      audio_drive_update,
  // drive references
  output logic [7:0]                full_scale_ref,
  output logic [7:0]                overdrive_bound,
  output logic [7:0]                cal_rated_level
);

  localparam int IDX_W = $clog2(MAX_SEGS);

  typedef struct packed {
    logic [7:0]                  brake_adj;
    logic [1:0]                  peak_sel;
    logic [1:0]                  lowpass_sel;
    logic [7:0]                  in_floor;
    logic [7:0]                  in_full;
    logic [7:0]                  drv_floor;
    logic [7:0]                  drv_ceil;
    logic [7:0]                  nominal;
    logic [7:0]                  od_limit;
    logic [7:0]                  rdata;
    logic                        rvalid;
    wave_state_type              wstate;
    logic [MAX_SEGS-1:0][19:0]   segs;
    logic [IDX_W:0]              seg_count;
    logic [IDX_W:0]              play_idx;
    logic [IDX_W:0]              brake_idx;
    logic signed [7:0]           min_level;
    logic                        out_valid;
    logic signed [7:0]           out_level;
    logic [11:0]                 out_dur;
    logic                        out_last;
    logic                        out_brake;
    logic [31:0]                 tick_cnt;
    logic [5:0]                  ms_cnt;
    logic [7:0]                  peak;
    logic [7:0]                  filt;
    logic [7:0]                  drive;
    logic                        drive_upd;
    logic [7:0]                  fs_ref;
  } state_type;

  state_type state_reg;
  state_type state_next;

  function automatic logic [7:0] lowpass_gain(input logic [1:0] sel);
    case (sel)
      2'h0:    lowpass_gain = LOWPASS_GAIN_0;
      2'h1:    lowpass_gain = LOWPASS_GAIN_1;
      2'h2:    lowpass_gain = LOWPASS_GAIN_2;
      default: lowpass_gain = LOWPASS_GAIN_3;
    endcase
  endfunction : lowpass_gain

  function automatic logic [5:0] peak_window_ms(input logic [1:0] sel);
    peak_window_ms = 6'((int'(sel) + 1) * PEAK_WINDOW_STEP_MS);
  endfunction : peak_window_ms

  // combinational helpers
  logic                 tick;
  logic signed [13:0]   adj_ms;
  logic signed [13:0]   brake_dur;
  logic [19:0]          cur_seg;
  logic signed [9:0]    filt_step;
  logic signed [19:0]   filt_prod;
  logic [15:0]          span_num;
  logic [7:0]           span_den;
  logic [7:0]           drv_span;
  logic [15:0]          scaled;
  logic [8:0]           mapped;
  logic [7:0]           new_drive;

  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.out_valid = 1'b0;
    state_next.drive_upd = 1'b0;

    // register port
    if (reg_write)
    begin
      case (reg_addr)
        ADDR_STOP_PHASE_TIME_ADJUST:  state_next.brake_adj = reg_wdata;
        ADDR_AUDIO_VIBE_PATH_CONTROL:
        begin
          state_next.peak_sel    = reg_wdata[PEAK_SEL_LSB +: 2];
          state_next.lowpass_sel = reg_wdata[LOWPASS_SEL_LSB +: 2];
        end
        ADDR_AUDIO_INPUT_FLOOR:       state_next.in_floor = reg_wdata;
        ADDR_AUDIO_INPUT_FULL_SCALE:  state_next.in_full = reg_wdata;
        ADDR_VIBE_DRIVE_FLOOR:        state_next.drv_floor = reg_wdata;
        ADDR_VIBE_DRIVE_CEILING:      state_next.drv_ceil = reg_wdata;
        ADDR_MOTOR_NOMINAL_LEVEL:     state_next.nominal = reg_wdata;
        ADDR_OVERDRIVE_LIMIT_LEVEL:   state_next.od_limit = reg_wdata;
        default:                      ;
      endcase
    end
    if (reg_read)
    begin
      state_next.rvalid = 1'b1;
      case (reg_addr)
        ADDR_STOP_PHASE_TIME_ADJUST:  state_next.rdata = state_reg.brake_adj;
        ADDR_AUDIO_VIBE_PATH_CONTROL:
          state_next.rdata = {4'h0, state_reg.peak_sel, state_reg.lowpass_sel};
        ADDR_AUDIO_INPUT_FLOOR:       state_next.rdata = state_reg.in_floor;
        ADDR_AUDIO_INPUT_FULL_SCALE:  state_next.rdata = state_reg.in_full;
        ADDR_VIBE_DRIVE_FLOOR:        state_next.rdata = state_reg.drv_floor;
        ADDR_VIBE_DRIVE_CEILING:      state_next.rdata = state_reg.drv_ceil;
        ADDR_MOTOR_NOMINAL_LEVEL:     state_next.rdata = state_reg.nominal;
        ADDR_OVERDRIVE_LIMIT_LEVEL:   state_next.rdata = state_reg.od_limit;
        default:                      state_next.rdata = 8'h00;
      endcase
    end

    // full-scale reference follows the loop mode
    state_next.fs_ref = closed_loop ? state_reg.nominal : state_reg.od_limit;

    // waveform: gather a whole waveform first, since the brake segment is only known at the end
    adj_ms = 14'(signed'(state_reg.brake_adj)) * 14'(STOP_PHASE_STEP_MS);
    cur_seg = state_reg.segs[IDX_W'(state_reg.play_idx)];
    brake_dur = signed'({2'b00, cur_seg[11:0]}) + adj_ms;
    case (state_reg.wstate)
      COLLECT:
      begin
        if (wave_in_valid)
        begin
          state_next.segs[IDX_W'(state_reg.seg_count)] = {wave_in_level, wave_in_dur_ms};
          state_next.seg_count = state_reg.seg_count + 1'b1;
          if (state_reg.seg_count == '0 || wave_in_level < state_reg.min_level)
          begin
            state_next.min_level = wave_in_level;
            state_next.brake_idx = state_reg.seg_count;
          end
          // a waveform longer than the store is cut at its last slot
          if (wave_in_last || state_reg.seg_count == (IDX_W + 1)'(MAX_SEGS - 1))
          begin
            state_next.wstate = PLAY;
            state_next.play_idx = '0;
          end
        end
      end
      PLAY:
      begin
        state_next.out_valid = 1'b1;
        state_next.out_level = signed'(cur_seg[19:12]);
        state_next.out_dur = cur_seg[11:0];
        state_next.out_brake = (state_reg.play_idx == state_reg.brake_idx);
        if (state_reg.play_idx == state_reg.brake_idx && !closed_loop)
        begin
          if (brake_dur < 0)
            state_next.out_dur = 12'h000;
          else if (brake_dur > 14'sh0fff)
            state_next.out_dur = 12'hfff;
          else
            state_next.out_dur = brake_dur[11:0];
        end
        state_next.play_idx = state_reg.play_idx + 1'b1;
        state_next.out_last = (state_reg.play_idx + 1'b1 == state_reg.seg_count);
        if (state_next.out_last)
        begin
          state_next.wstate = COLLECT;
          state_next.seg_count = '0;
        end
      end
      default:
        state_next.wstate = COLLECT;
    endcase

    // audio path runs on a 1 ms enable
    tick = (state_reg.tick_cnt == 32'(TICK_CYCLES - 1));
    state_next.tick_cnt = tick ? 32'h0 : state_reg.tick_cnt + 32'h1;
    if (audio_level > state_reg.peak)
      state_next.peak = audio_level;
    filt_step = 10'(signed'({2'b00, state_reg.peak}) - signed'({2'b00, state_reg.filt}));
    // 20 bits: a full swing times the largest gain overflows 16
    filt_prod = 20'(filt_step) * 20'(signed'({2'b00, lowpass_gain(state_reg.lowpass_sel)}));
    span_num = 16'h0;
    span_den = state_reg.in_full - state_reg.in_floor;
    drv_span = (state_reg.drv_ceil > state_reg.drv_floor) ?
               state_reg.drv_ceil - state_reg.drv_floor : 8'h00;
    scaled = 16'h0;
    mapped = 9'h0;
    new_drive = 8'h00;
    if (state_reg.filt < state_reg.in_floor)
      new_drive = 8'h00;
    else if (state_reg.filt >= state_reg.in_full)
      new_drive = state_reg.drv_ceil;
    else
    begin
      span_num = 16'(state_reg.filt - state_reg.in_floor) * 16'(drv_span);
      scaled = span_num / 16'(span_den);
      mapped = 9'(state_reg.drv_floor) + scaled[8:0];
      new_drive = mapped[7:0];
      if (mapped > 9'(state_reg.drv_ceil))
        new_drive = state_reg.drv_ceil;
      else if (mapped < 9'(state_reg.drv_floor))
        new_drive = state_reg.drv_floor;
    end
    // a ceiling set under the floor wins, so the drive stays bounded above
    if (new_drive > state_reg.drv_ceil)
      new_drive = state_reg.drv_ceil;
    if (tick)
    begin
      state_next.drive = new_drive;
      state_next.drive_upd = 1'b1;
      // one-pole low-pass sampled once per millisecond on the held peak
      state_next.filt = 8'(16'(state_reg.filt) + 16'(filt_prod >>> 8));
      if (state_reg.ms_cnt + 1'b1 >= peak_window_ms(state_reg.peak_sel))
      begin
        state_next.ms_cnt = 6'h0;
        state_next.peak = audio_level;
      end
      else
        state_next.ms_cnt = state_reg.ms_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.brake_adj <= RST_STOP_PHASE_TIME_ADJUST;
      state_reg.peak_sel <= RST_AUDIO_PEAK_WINDOW_SEL;
      state_reg.lowpass_sel <= RST_AUDIO_LOWPASS_SEL;
      state_reg.in_floor <= RST_AUDIO_INPUT_FLOOR;
      state_reg.in_full <= RST_AUDIO_INPUT_FULL_SCALE;
      state_reg.drv_floor <= RST_VIBE_DRIVE_FLOOR;
      state_reg.drv_ceil <= RST_VIBE_DRIVE_CEILING;
      state_reg.nominal <= RST_MOTOR_NOMINAL_LEVEL;
      state_reg.od_limit <= RST_OVERDRIVE_LIMIT_LEVEL;
      state_reg.wstate <= COLLECT;
    end
    else
      state_reg <= state_next;
  end

  assign reg_rdata          = state_reg.rdata;
  assign reg_rvalid         = state_reg.rvalid;
  // collect is the low one-hot bit, so ready comes straight off a flop
  assign wave_in_ready      = state_reg.wstate[0];
  assign wave_out_valid     = state_reg.out_valid;
  assign wave_out_level     = state_reg.out_level;
  assign wave_out_dur_ms    = state_reg.out_dur;
  assign wave_out_last      = state_reg.out_last;
  assign wave_out_brake     = state_reg.out_brake;
  assign audio_drive        = state_reg.drive;
  assign audio_drive_update = state_reg.drive_upd;
  assign full_scale_ref     = state_reg.fs_ref;
  assign overdrive_bound    = state_reg.od_limit;
  assign cal_rated_level    = state_reg.nominal;

endmodule : haptic_brake_audio_vibe_cfg

// *** sim/haptic_chk.sv ***
module haptic_chk (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // register port
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic       reg_rvalid,
  // waveform
  input wire logic       closed_loop,
  input wire logic       wave_in_valid,
  input wire logic       wave_in_ready,
  input wire logic       wave_in_last,
  input wire logic       wave_out_valid,
  input wire logic       wave_out_last,
  // audio and references
  input wire logic [7:0] audio_drive,
  input wire logic       audio_drive_update,
  input wire logic [7:0] full_scale_ref,
  input wire logic [7:0] overdrive_bound,
  input wire logic [7:0] cal_rated_level
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rd;
    reg_read |=> reg_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_norv;
    !reg_read |=> !reg_rvalid;
  endproperty
  a_norv: assert property (p_norv) else $error("stray read answer");
  property p_keep;
    !reg_write |=> $stable(cal_rated_level) && $stable(overdrive_bound);
  endproperty
  a_keep: assert property (p_keep) else $error("register moved without write");
  property p_cl;
    !rst && closed_loop |=> full_scale_ref == $past(cal_rated_level);
  endproperty
  a_cl: assert property (p_cl) else $error("closed loop reference wrong");
  property p_ol;
    !rst && !closed_loop |=> full_scale_ref == $past(overdrive_bound);
  endproperty
  a_ol: assert property (p_ol) else $error("open loop reference wrong");
  property p_hold;
    !audio_drive_update |-> $stable(audio_drive);
  endproperty
  a_hold: assert property (p_hold) else $error("drive moved off tick");
  property p_play;
    wave_in_valid && wave_in_ready && wave_in_last |=> !wave_in_ready ##1 wave_out_valid;
  endproperty
  a_play: assert property (p_play) else $error("playout not started");
  property p_done;
    wave_out_valid && wave_out_last |=> wave_in_ready && !wave_out_valid;
  endproperty
  a_done: assert property (p_done) else $error("playout end wrong");
endmodule : haptic_chk

// *** sim/host_model.sv ***
module host_model (
  // clock
  input wire logic       clock,
  // register port
  output logic     [7:0] reg_addr,
  output logic     [7:0] reg_wdata,
  output logic           reg_write,
  output logic           reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // released data never shows the old byte
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : host_model

// *** sim/test_haptic_brake_audio_vibe_cfg.sv ***
module test_haptic_brake_audio_vibe_cfg;
  import haptic_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  logic clock, rst, reg_write, reg_read, reg_rvalid, closed_loop;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, audio_level, audio_drive;
  logic [7:0] full_scale_ref, overdrive_bound, cal_rated_level, r, ce, ex;
  logic wave_in_valid, wave_in_last, wave_in_ready, audio_drive_update;
  logic wave_out_valid, wave_out_last, wave_out_brake;
  logic signed [7:0] wave_in_level, wave_out_level;
  logic [11:0] wave_in_dur_ms, wave_out_dur_ms;
  logic [7:0] mdl [8];
  logic [31:0] seed = 32'he53b;
  int mismatches, checks, pulses;
  haptic_brake_audio_vibe_cfg #(.TICK_CYCLES(TICK), .MAX_SEGS(8)) i_haptic_brake_audio_vibe_cfg (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
    .closed_loop, .wave_in_valid, .wave_in_level, .wave_in_dur_ms, .wave_in_last,
    .wave_in_ready, .wave_out_valid, .wave_out_level, .wave_out_dur_ms, .wave_out_last,
    .wave_out_brake, .audio_level, .audio_drive, .audio_drive_update, .full_scale_ref,
    .overdrive_bound, .cal_rated_level);
  host_model i_host_model (
    .clock, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid);
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host_model.rd(a, d, ok);
    check(ok, 1'b1, "read answer");
    check(d, exp, "read data");
  endtask : rd_chk
  task automatic put(input int a, input logic [7:0] v);
    i_host_model.wr(8'h10 + 8'(a), v);
    mdl[a] = (a == 1) ? (v & 8'h0f) : v;
  endtask : put
  task automatic play(input int n);
    logic signed [7:0] lv [8];
    logic [11:0] du [8];
    int b, e, k;
    b = 0;
    for (int i = 0; i < n; i++)
    begin
      lv[i] = rnd8();
      du[i] = {4'(rnd8()), rnd8()};
      if (lv[i] < lv[b]) b = i;
    end
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      wave_in_valid <= 1'b1;
      wave_in_level <= lv[i];
      wave_in_dur_ms <= du[i];
      wave_in_last <= (i == n - 1);
    end
    @(posedge clock);
    wave_in_valid <= 1'b0;
    for (k = 0; k < 20 && wave_out_valid !== 1'b1; k++) @(negedge clock);
    for (int i = 0; i < n; i++)
    begin
      e = du[i];
      // stop phase stretched in open loop only, clamped to the field
      if (i == b && !closed_loop) e = e + int'($signed(mdl[0])) * 5;
      e = (e < 0) ? 0 : (e > 4095) ? 4095 : e;
      check(wave_out_valid, 1'b1, "segment out");
      check(wave_out_level, lv[i], "segment level");
      check(wave_out_dur_ms, 12'(e), "segment time");
      check(wave_out_brake, i == b, "stop phase mark");
      check(wave_out_last, i == n - 1, "last mark");
      @(negedge clock);
    end
    check(wave_in_ready, 1'b1, "ready again");
  endtask : play
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (50000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    closed_loop = 1'b0;
    wave_in_valid = 1'b0;
    wave_in_level = 8'sh00;
    wave_in_dur_ms = 12'h000;
    wave_in_last = 1'b0;
    audio_level = 8'h00;
    mdl = '{RST_STOP_PHASE_TIME_ADJUST, {4'h0, RST_AUDIO_PEAK_WINDOW_SEL, RST_AUDIO_LOWPASS_SEL},
            RST_AUDIO_INPUT_FLOOR, RST_AUDIO_INPUT_FULL_SCALE, RST_VIBE_DRIVE_FLOOR,
            RST_VIBE_DRIVE_CEILING, RST_MOTOR_NOMINAL_LEVEL, RST_OVERDRIVE_LIMIT_LEVEL};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk(8'h10 + 8'(a), mdl[a]);
    rd_chk(8'h20, 8'h00);
    // overdrive limit written first, then nominal level, as a host does before calibrating
    for (int a = 7; a >= 0; a--) put(a, rnd8());
    i_host_model.wr(8'h20, rnd8());
    for (int a = 0; a < 8; a++) rd_chk(8'h10 + 8'(a), mdl[a]);
    rd_chk(8'h20, 8'h00);
    check(cal_rated_level, mdl[6], "calibration level");
    check(overdrive_bound, mdl[7], "overdrive bound");
    @(posedge clock);
    closed_loop <= 1'b1;
    repeat (2) @(negedge clock);
    check(full_scale_ref, mdl[6], "closed reference");
    for (int k = 0; k < 4; k++)
    begin
      put(0, rnd8());
      @(posedge clock);
      closed_loop <= k[0];
      @(negedge clock);
      play(k == 3 ? 8 : 1 + rnd8() % 7);
    end
    // the last waveform ran in closed loop, so return to open loop first
    @(posedge clock);
    closed_loop <= 1'b0;
    repeat (2) @(negedge clock);
    check(full_scale_ref, mdl[7], "open reference");
    r = rnd8();
    ce = 8'h40 + (r & 8'h7f);
    put(2, 8'h20);
    put(3, 8'h80);
    put(4, 8'h30);
    put(5, ce);
    @(posedge clock);
    audio_level <= 8'hff;
    for (int c = 0; c < 4; c++)
    begin
      put(1, {4'h0, 2'(c), 2'(c)});
      repeat (40 * TICK) @(negedge clock);
      check(audio_drive, ce, "ceiling");
    end
    @(posedge clock);
    audio_level <= 8'h10;
    repeat (60 * TICK) @(negedge clock);
    check(audio_drive, 8'h00, "below floor");
    @(posedge clock);
    audio_level <= 8'h50;
    repeat (60 * TICK) @(negedge clock);
    ex = 8'(8'h30 + 32'h30 * (ce - 8'h30) / 32'h60);
    check(audio_drive >= 8'h30 && audio_drive <= ce, 1'b1, "drive range");
    check(audio_drive + 8'h04 >= ex && audio_drive <= ex + 8'h04, 1'b1, "linear map");
    // one update pulse per tick, whatever the phase of the window
    pulses = 0;
    repeat (4 * TICK)
    begin
      @(negedge clock);
      pulses += audio_drive_update;
    end
    check(12'(pulses), 12'h004, "tick pulses");
    give_verdict();
  end
endmodule : test_haptic_brake_audio_vibe_cfg
bind haptic_brake_audio_vibe_cfg haptic_chk i_haptic_chk (
  .clock, .rst, .reg_write, .reg_read, .reg_rvalid, .closed_loop, .wave_in_valid,
  .wave_in_ready, .wave_in_last, .wave_out_valid, .wave_out_last, .audio_drive,
  .audio_drive_update, .full_scale_ref, .overdrive_bound, .cal_rated_level);
